// File: bench/cwf_link_sva.sv
// Purpose: link-level checks between the host end and the device end
// Assumes: one clock, frames sent one byte per cycle
// Notes:   crc over a whole frame, crc bytes included, leaves zero
`timescale 1ns/1ps
`default_nettype none
module cwf_link_sva
  import cwf_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // link
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       frame_end,
  input wire logic       frame_err,
  input wire logic       fault_oe,
  input wire logic       fault_output_n
);
  logic        first;
  logic [15:0] crc;
  logic        spc;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  assign spc = first && byte_valid && (byte_data == SPC_RESET_HDR || byte_data == SPC_UPDATE_HDR);
  // first marks the header slot; a frame_end reopens it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first <= 1'b1;
      crc   <= CRC_INIT;
    end else if (byte_valid) begin
      first <= frame_end;
      crc   <= frame_end ? CRC_INIT : crc_step(crc, byte_data);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_pin_low_hold: assert property ($fell(fault_output_n) |=> !fault_output_n || $past(frame_end))
    else $error("fault pin released one cycle after going low");
  a_reset_idle: assert property ($rose(nrst) |-> !fault_oe)
    else $error("fault pin driven after reset");
  a_end_on_byte: assert property (frame_end |-> byte_valid)
    else $error("frame end without a byte");
  a_no_err: assert property (frame_err == 1'b0)
    else $error("host flagged a parity error");
  a_back_to_back: assert property (byte_valid && !frame_end |=> byte_valid)
    else $error("gap inside a frame");
  a_special_id: assert property (spc |=> byte_valid && byte_data == BCAST_ID)
    else $error("special command without broadcast id");
  a_special_len: assert property (spc |-> ##3 frame_end)
    else $error("special command not four bytes");
  a_write_len: assert property (first && byte_valid && byte_data == 8'h80 |-> ##5 frame_end)
    else $error("write frame not six bytes");
  a_crc_residue: assert property (byte_valid && frame_end |-> crc_step(crc, byte_data) == 16'h0000)
    else $error("frame crc wrong");
  c_reset_cmd: cover property (first && byte_valid && byte_data == SPC_RESET_HDR);
  c_update_cmd: cover property (first && byte_valid && byte_data == SPC_UPDATE_HDR);
  c_fault_low: cover property ($fell(fault_output_n));
endmodule
`default_nettype wire

// File: bench/test_comm_watchdog_failsafe_ctrl.sv
// Purpose: host end against device end, watchdog and fail-safe modes
// Assumes: tap shortened to bit 4 by register write
// Notes:   live mode change inside fail-safe is not exercised
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_comm_watchdog_failsafe_ctrl;
  import cwf_pkg::*;
  logic              ref_clk, nrst, req_valid, req_ready, fault_seen, analog_fault;
  logic [1:0]        req_kind, fs_sel;
  logic [7:0]        req_addr, req_data, fault_type_reg;
  logic [NCH*12-1:0] norm_pwm, def_pwm, led_pwm;
  logic              led_enable, in_failsafe, update_pulse, protect_active;
  wire logic         fo_n;
  int                fails = 0, n_checks = 0, seed = 87, n_upd = 0, i, k;
  cwf_link_if cwf_link_if_i (.ref_clk);
  assign fo_n = cwf_link_if_i.fault_output_n;
  cwf_device cwf_device_i (.ref_clk, .nrst, .link(cwf_link_if_i.dev), .failsafe_mode_select_input(fs_sel),
    .analog_fault, .norm_pwm, .def_pwm, .led_pwm, .led_enable, .in_failsafe, .update_pulse,
    .protect_active, .fault_type_reg);
  cwf_host cwf_host_i (.ref_clk, .nrst, .link(cwf_link_if_i.host), .req_valid, .req_kind, .req_addr,
    .req_data, .req_ready, .fault_seen);
  cwf_link_sva cwf_link_sva_i (.ref_clk, .nrst, .byte_valid(cwf_link_if_i.byte_valid),
    .byte_data(cwf_link_if_i.byte_data), .frame_end(cwf_link_if_i.frame_end),
    .frame_err(cwf_link_if_i.frame_err), .fault_oe(cwf_link_if_i.fault_oe), .fault_output_n(fo_n));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (update_pulse === 1'b1) n_upd++;
  end
  function automatic logic [NCH*12-1:0] rnd();
    logic [159:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    return r[NCH*12-1:0];
  endfunction
  // outputs expected while a fail-safe mode is active
  function automatic logic [NCH*12-1:0] exp_pwm(input int md);
    return (md == 1) ? def_pwm : (md == 3) ? {NCH{PWM_98}} : norm_pwm;
  endfunction
  task automatic stop_test();
    $display("fails=%0d checks=%0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // every wait is bounded here, so a stuck handshake ends the run
  task automatic tick();
    @(posedge ref_clk);
    #1;
    i++;
    if (i > 600) begin
      fails++;
      $display("ERROR %0t wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic req(input logic [1:0] kd, input logic [7:0] a, input logic [7:0] d);
    i = 0;
    while (req_ready !== 1'b1) tick();
    req_kind = kd;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    while (req_ready !== 1'b1) tick();
    repeat (2) tick();
  endtask
  initial begin
    {nrst, req_valid, req_kind, req_addr, req_data, fs_sel, analog_fault} = '0;
    norm_pwm = '0;
    def_pwm = '0;
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    i = 0;
    tick();
    `CHK(led_enable, 1'b0)
    `CHK(fault_type_reg, 8'h00)
    `CHK(fo_n, 1'b1)
    for (int m = 0; m < 4; m++) begin
      fs_sel = m[1:0];
      norm_pwm = rnd();
      def_pwm = rnd();
      req(2'd2, SYS_CFG_ADDR, 8'h04);
      req(2'd2, FAULT_SETUP_ADDR, (m == 0) ? 8'h00 : 8'(m - 1));
      req(2'd1, 8'h00, 8'h00);
      `CHK(in_failsafe, 1'b0)
      `CHK(led_pwm, norm_pwm)
      i = 0;
      while (in_failsafe !== 1'b1 && i < 60) tick();
      if (m == 0) begin
        `CHK(in_failsafe, 1'b0)
        `CHK(led_pwm, norm_pwm)
      end else begin
        `CHK(i > 8 && i < 18, 1'b1)
        `CHK(fault_type_reg[WDOG_FLAG_BIT], 1'b1)
        if (m > 1) `CHK(fo_n, 1'b1)
        `CHK(led_enable, 1'(m != 2))
        if (m != 2) `CHK(led_pwm, exp_pwm(m))
        analog_fault = 1'($random(seed));
        tick();
        `CHK(protect_active, analog_fault)
        if (m == 3) `CHK(fault_type_reg[OPEN_FLAG_BIT], 1'b1)
        i = 0;
        while (fo_n !== 1'b0) tick();
        `CHK(i >= (m - 1) * FDLY_STEP_CYC && i <= (m - 1) * FDLY_STEP_CYC + 3, 1'b1)
        tick();
        `CHK(fault_seen, 1'b1)
        // long tap so the watchdog stays quiet while the pin releases
        req(2'd2, SYS_CFG_ADDR, 8'h10);
        req(2'd3, FAULT_TYPE_ADDR, 8'h00);
        `CHK(in_failsafe, 1'b0)
        `CHK(fault_type_reg[WDOG_FLAG_BIT], 1'b0)
        i = 0;
        while (fo_n !== 1'b1) tick();
        `CHK(i >= (m - 1) * FDLY_STEP_CYC && i <= (m - 1) * FDLY_STEP_CYC + 3, 1'b1)
        if (m == 3) begin
          req(2'd2, FAULT_TYPE_ADDR, 8'h00);
          `CHK(fault_type_reg[OPEN_FLAG_BIT], 1'b0)
        end
      end
    end
    req(2'd0, 8'h00, 8'h00);
    `CHK(led_enable, 1'b0)
    `CHK(fault_type_reg, 8'h00)
    fs_sel = 2'b01;
    k = n_upd;
    req(2'd1, 8'h00, 8'h00);
    `CHK(n_upd, k + 1)
    i = 0;
    repeat (60) tick();
    `CHK(in_failsafe, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire

// File: hdl/cwf_device.sv
// Purpose: communication watchdog and operating-state controller, device end
// Assumes: byte stream from a UART deframer; parity error reported on frame_err
// Notes:   register writes come as plain frames: header 0x80, id, addr, data, crc
// Function
// RULE1: register-reset broadcast BE,BF,crc resets all
// RULE2: update broadcast B8,BF,crc to all devices
// RULE3: after undervoltage release, init: defaults, outputs off
// RULE4: normal state drives outputs from registers
// RULE5: 25-bit watchdog counter, tap from register 4Ah
// RULE6: tap resets to bit 22
// RULE7: timeout with watchdog active enters fail-safe
// RULE8: mode follows four-level select input live
// RULE9: disabled: watchdog inactive, normal registers drive
// RULE10: mode 1 uses default registers
// RULE11: mode 2 forces outputs off
// RULE12: mode 3 forces outputs on at 98%
// RULE13: set watchdog flag; fault pin low after delay
// RULE14: clearing flag exits, resets counter, releases pin
// RULE15: host reinitializes configuration after exit
// RULE16: fault protection stays active in fail-safe
// RULE17: mode 3 sets open flag; host clears
// RULE18: CRC reflected A001, zero init, low byte first
// RULE19: good frame restarts counter; disabled holds clear
// RULE20: select input two-bit code 00..11
`timescale 1ns/1ps
`default_nettype none
module cwf_device
  import cwf_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // link
  cwf_link_if.dev                link,
  // analog side
  input  wire logic [1:0]        failsafe_mode_select_input,
  input  wire logic              analog_fault,
  input  wire logic [NCH*12-1:0] norm_pwm,
  input  wire logic [NCH*12-1:0] def_pwm,
  // outputs
  output logic      [NCH*12-1:0] led_pwm,
  output logic                   led_enable,
  output logic                   in_failsafe,
  output logic                   update_pulse,
  output logic                   protect_active,
  output logic      [7:0]        fault_type_reg
);
  typedef enum logic [1:0] {ST_INIT, ST_NORMAL, ST_FAILSAFE} cwf_state_t;

  typedef struct packed {
    cwf_state_t          state;
    cwf_fsmode_t         fs_mode;
    logic [WDOG_W-1:0]   wdog;
    logic [4:0]          watchdog_tap_select;
    logic [FDLY_W-1:0]   fault_report_delay;
    logic                comm_watchdog_fault_flag;
    logic                led_open_fault_flag;
    logic [2:0]          pos;
    logic [7:0]          hdr;
    logic [7:0]          id;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic [15:0]         crc;
    logic [15:0]         crc_rx;
    logic                fault_lvl;
    logic [FDLY_W+7:0]   dly_cnt;
    logic                fault_oe;
    logic                upd;
  } cwf_dev_t;

  cwf_dev_t r, next_r;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1); // RULE18
    end
    return x;
  endfunction

  logic frame_ok;
  logic is_reset_cmd;
  logic crc_good;
  logic [FDLY_W+7:0] dly_target;
  logic [15:0]       crc_fin;

  always_comb begin
    // the frame-end byte is still on the link: fold the last covered byte and
    // take the high crc byte from the link, not from registered state
    crc_fin      = (r.pos >= 3'd4) ? crc_byte(r.crc, r.crc_rx[7:0]) : r.crc; // RULE18
    crc_good     = link.byte_valid && (crc_fin == {link.byte_data, r.crc_rx[15:8]}); // RULE18
    frame_ok     = link.frame_end && !link.frame_err && crc_good;
    is_reset_cmd = frame_ok && r.pos == 3'd3 && r.hdr == SPC_RESET_HDR && r.id == BCAST_ID; // RULE1
    dly_target   = (FDLY_W + 8)'(r.fault_report_delay * FDLY_STEP_CYC);
    next_r = r;
    next_r.upd = 1'b0;
    // byte assembly; crc covers everything before the two crc bytes
    if (link.byte_valid) begin
      next_r.pos = (r.pos == 3'd7) ? r.pos : r.pos + 3'd1;
      next_r.crc_rx = {link.byte_data, r.crc_rx[15:8]}; // RULE18
      next_r.crc = r.pos < 3'd2 ? crc_byte(r.crc, link.byte_data) : r.crc;
      case (r.pos)
        3'd0: begin
          next_r.hdr = link.byte_data;
        end
        3'd1: begin
          next_r.id = link.byte_data;
        end
        default: begin
        end
      endcase
      if (r.pos >= 3'd2) begin
        // last two bytes are only the crc when the frame ends; fold older byte in late
        next_r.crc = (r.pos >= 3'd4) ? crc_byte(r.crc, r.crc_rx[7:0]) : r.crc;
        if (r.pos == 3'd2) next_r.addr = link.byte_data;
        if (r.pos == 3'd3) next_r.wdata = link.byte_data;
      end
    end
    if (link.frame_end) begin
      next_r.pos = 3'd0;
      next_r.crc = CRC_INIT;
      next_r.crc_rx = 16'h0000;
    end
    // mode select is followed live
    next_r.fs_mode = cwf_fsmode_t'(failsafe_mode_select_input); // RULE8 RULE20
    case (r.state)
      ST_INIT: begin
        if (frame_ok) next_r.state = ST_NORMAL; // RULE3
      end
      ST_NORMAL: begin
        if (r.fs_mode != FS_OFF && r.wdog[r.watchdog_tap_select]) begin
          next_r.state = ST_FAILSAFE; // RULE7
          next_r.comm_watchdog_fault_flag = 1'b1; // RULE13
          if (r.fs_mode == FS_M3) next_r.led_open_fault_flag = 1'b1; // RULE17
        end
      end
      ST_FAILSAFE: begin
        if (!r.comm_watchdog_fault_flag) begin
          next_r.state = ST_NORMAL; // RULE14
          next_r.wdog = '0;
        end
      end
      default: next_r.state = ST_INIT;
    endcase
    // watchdog counter
    if (r.fs_mode == FS_OFF || r.state != ST_NORMAL || frame_ok) begin
      next_r.wdog = '0; // RULE9 RULE19
    end else begin
      next_r.wdog = r.wdog + 25'h0000001; // RULE5
    end
    // register writes: 4-byte header+id+addr+data plus crc
    if (frame_ok && r.pos == 3'd5 && r.hdr[7] && !r.hdr[6]) begin
      if (r.addr == SYS_CFG_ADDR) next_r.watchdog_tap_select = r.wdata[TAP_LSB +: 5]; // RULE5
      if (r.addr == FAULT_SETUP_ADDR) next_r.fault_report_delay = r.wdata[FDLY_LSB +: FDLY_W];
      if (r.addr == FAULT_TYPE_ADDR) begin
        // set wins for the watchdog flag: one raised this cycle survives the clear; the open flag only clears outside fail-safe
        if (!r.wdata[WDOG_FLAG_BIT] && !(next_r.state == ST_FAILSAFE && r.state == ST_NORMAL))
          next_r.comm_watchdog_fault_flag = 1'b0; // RULE14
        if (!r.wdata[OPEN_FLAG_BIT] && r.state != ST_FAILSAFE)
          next_r.led_open_fault_flag = 1'b0; // RULE17
      end
    end
    if (frame_ok && r.pos == 3'd3 && r.hdr == SPC_UPDATE_HDR && r.id == BCAST_ID)
      next_r.upd = 1'b1; // RULE2
    // delayed fault pin follows the flag level
    if (r.comm_watchdog_fault_flag != r.fault_lvl) begin
      next_r.fault_lvl = r.comm_watchdog_fault_flag;
      next_r.dly_cnt = '0;
    end else if (r.fault_oe != r.fault_lvl) begin
      if (r.dly_cnt >= dly_target) next_r.fault_oe = r.fault_lvl; // RULE13 RULE14
      else next_r.dly_cnt = r.dly_cnt + 12'h001;
    end
    if (is_reset_cmd) begin
      next_r = '0; // RULE1 RULE3
      next_r.watchdog_tap_select = TAP_RESET;
      next_r.fault_report_delay = FDLY_RESET;
      next_r.fs_mode = cwf_fsmode_t'(failsafe_mode_select_input);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{state: ST_INIT, fs_mode: FS_OFF, watchdog_tap_select: TAP_RESET, // RULE3 RULE6
             fault_report_delay: FDLY_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // output mux
  always_comb begin
    led_pwm    = norm_pwm; // RULE4 RULE9
    led_enable = (r.state != ST_INIT); // RULE3
    if (r.state == ST_FAILSAFE) begin
      case (r.fs_mode)
        FS_M1: led_pwm = def_pwm; // RULE10
        FS_M2: led_enable = 1'b0; // RULE11
        FS_M3: led_pwm = {NCH{PWM_98}}; // RULE12
        default: led_pwm = norm_pwm;
      endcase
    end
  end

  // analog protection is never masked by fail-safe
  assign protect_active = analog_fault; // RULE16
  assign in_failsafe    = (r.state == ST_FAILSAFE);
  assign update_pulse   = r.upd;
  assign link.fault_oe  = r.fault_oe;
  assign fault_type_reg = {6'h00, r.led_open_fault_flag, r.comm_watchdog_fault_flag};
endmodule
`default_nettype wire

// File: hdl/cwf_host.sv
// Purpose: host end: sends frames with CRC, special commands, fault clearing
// Assumes: one byte per cycle on the link
// Notes:   after clearing the flag the user must rewrite configuration
`timescale 1ns/1ps
`default_nettype none
module cwf_host
  import cwf_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // link
  cwf_link_if.host        link,
  // user requests
  input  wire logic       req_valid,
  input  wire logic [1:0] req_kind,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  // status
  output logic            fault_seen
);
  typedef struct packed {
    logic       busy;
    logic [2:0] idx;
    logic [2:0] len;
    logic [47:0] bytes;
    logic [15:0] crc;
    logic        bv;
    logic [7:0]  bd;
    logic        fe;
    logic        flt;
  } cwf_host_t;

  cwf_host_t r, next_r;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1); // RULE18
    end
    return x;
  endfunction

  always_comb begin
    next_r = r;
    next_r.bv = 1'b0;
    next_r.fe = 1'b0;
    next_r.flt = ~link.fault_output_n;
    if (!r.busy && req_valid) begin
      next_r.busy = 1'b1;
      next_r.idx = 3'd0;
      next_r.crc = CRC_INIT;
      case (req_kind)
        2'd0: begin
          next_r.bytes = {32'h0, BCAST_ID, SPC_RESET_HDR}; // RULE1
          next_r.len = 3'd2;
        end
        2'd1: begin
          next_r.bytes = {32'h0, BCAST_ID, SPC_UPDATE_HDR}; // RULE2
          next_r.len = 3'd2;
        end
        default: begin
          // write; kind 3 writes 00h to 57h: clears the watchdog flag, and the open flag only outside fail-safe
          next_r.bytes = {16'h0, (req_kind == 2'd3) ? 8'h00 : req_data,
                          (req_kind == 2'd3) ? FAULT_TYPE_ADDR : req_addr, BCAST_ID, 8'h80}; // RULE14 RULE17
          next_r.len = 3'd4;
        end
      endcase
    end else if (r.busy) begin
      next_r.bv = 1'b1;
      next_r.idx = r.idx + 3'd1;
      if (r.idx < r.len) begin
        next_r.bd = r.bytes[8*r.idx +: 8];
        next_r.crc = crc_byte(r.crc, r.bytes[8*r.idx +: 8]);
      end else if (r.idx == r.len) begin
        next_r.bd = r.crc[7:0]; // RULE18
      end else begin
        next_r.bd = r.crc[15:8];
        next_r.fe = 1'b1;
        next_r.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) r <= '0;
    else r <= next_r;
  end

  assign req_ready       = !r.busy;
  assign link.byte_valid = r.bv;
  assign link.byte_data  = r.bd;
  assign link.frame_end  = r.fe;
  assign link.frame_err  = 1'b0;
  assign fault_seen      = r.flt;
endmodule
`default_nettype wire

// File: hdl/cwf_link_if.sv
// Purpose: link between host end and device end (deframed byte stream)
// Assumes: single clock ref_clk
// Notes:   fault_output_n is open drain; resolved here from its enable
`timescale 1ns/1ps
`default_nettype none
interface cwf_link_if (input wire logic ref_clk);
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       frame_end;
  logic       frame_err;
  logic       fault_oe;
  logic       fault_output_n;
  assign fault_output_n = ~fault_oe;
  modport dev  (input byte_valid, byte_data, frame_end, frame_err, output fault_oe);
  modport host (output byte_valid, byte_data, frame_end, frame_err, input fault_output_n);
endinterface
`default_nettype wire

// File: hdl/cwf_pkg.sv
// Purpose: shared constants for the watchdog/fail-safe controller and its host end
// Assumes: one 125 MHz clock, byte-wide frame stream already deframed
// Notes:   register addresses are the device's byte register addresses
package cwf_pkg;
  localparam logic [7:0]  SPC_RESET_HDR   = 8'hBE;
  localparam logic [7:0]  SPC_UPDATE_HDR  = 8'hB8;
  localparam logic [7:0]  BCAST_ID        = 8'hBF;
  localparam logic [15:0] CRC_POLY        = 16'hA001;
  localparam logic [15:0] CRC_INIT        = 16'h0000;
  localparam logic [7:0]  SYS_CFG_ADDR    = 8'h4A;
  localparam logic [7:0]  FAULT_TYPE_ADDR = 8'h57;
  localparam logic [7:0]  FAULT_SETUP_ADDR = 8'h58;
  localparam int          TAP_LSB         = 0;
  localparam logic [4:0]  TAP_RESET       = 5'h16;
  localparam int          WDOG_W          = 25;
  localparam int          WDOG_FLAG_BIT   = 0;
  localparam int          OPEN_FLAG_BIT   = 1;
  localparam int          FDLY_LSB        = 0;
  localparam int          FDLY_W          = 4;
  localparam logic [3:0]  FDLY_RESET      = 4'h0;
  // delay unit per fault_report_delay step, in us
  localparam int          FDLY_STEP_US    = 1;
  localparam int          CLK_MHZ         = 125;
  localparam int          FDLY_STEP_CYC   = (FDLY_STEP_US * CLK_MHZ < 1) ? 1 : FDLY_STEP_US * CLK_MHZ;
  localparam logic [11:0] PWM_98          = 12'hFAE;
  localparam logic [11:0] PWM_FULL_DEF    = 12'h000;
  localparam int          NCH             = 12;
  typedef enum logic [1:0] {FS_OFF, FS_M1, FS_M2, FS_M3} cwf_fsmode_t;
endpackage
